// ---- pme_access_engine.sv ----
// Purpose: Host access to PHY registers by read, write and scan commands
// Assumes: Host register port sampled on the system clock
// Notes: Busy follows a command by two clock cycles
//
// Functional notes
// - Five-bit address register selects PHY register
// - Read bit starts read, busy two cycles later
// - Read lasts 10.24 us, busy self-clears
// - High write byte starts write, busy later
// - Write commits at end, busy self-clears
// - Writes replace all sixteen bits at once
// - Scan bit starts repeated reads, flags set
// - Scan refreshes read data every interval
// - No refresh indication; bytes may mismatch
// - Scan clear ends after current read
// - Control one bit 8 selects duplex
// - Latched link bit drops on loss
// - Status one bits 12 and 11 read one
// - Force link bit always allows transmit
// - Pending clears when data lands
`timescale 1ns/100ps
`include "pme_defines.svh"
module pme_access_engine
   import pme_pkg::*;
#(
   parameter int TXN_CYCLES = `PME_TXN_CYCLES
) (
   input wire logic clock,            // System clock
   input wire logic rst,              // Synchronous reset
   input wire logic [2:0] sfr_addr,   // Host register index
   input wire logic sfr_write,        // Host write strobe
   input wire logic sfr_read,         // Host read strobe
   input wire logic [7:0] sfr_wdata,  // Host write data
   output logic [7:0] sfr_rdata,      // Read data, next cycle
   input wire logic mac_duplex_select, // MAC duplex setting
   input wire logic link_pin,         // PHY link up level
   input wire logic tx_pin,           // PHY transmitting
   input wire logic rx_pin,           // PHY receiving
   input wire logic col_pin,          // PHY collision
   output logic phy_duplex_select,    // PHY full duplex
   output logic duplex_mismatch,      // Duplex differ
   output logic force_link_up,        // Link forced up
   output logic tx_allowed,           // PHY may transmit
   output logic loopback_off_ctrl,    // Loopback off
   output logic rx_pair_normal_ctrl,  // Normal receive pair mode
   output logic [15:0] led_config     // LED control word
);
   pme_state_type state;
   pme_state_type next_state;
   pme_op_type op;
   pme_op_type next_op;
   logic [4:0] phy_reg_select;
   logic [4:0] next_reg_select;
   logic [1:0] mgmt_command_reg;
   logic [1:0] next_command;
   logic [7:0] mgmt_wdata_lo;
   logic [7:0] next_wdata_lo;
   logic [7:0] mgmt_wdata_hi;
   logic [7:0] next_wdata_hi;
   logic [7:0] mgmt_rdata_lo;
   logic [7:0] next_rdata_lo;
   logic [7:0] mgmt_rdata_hi;
   logic [7:0] next_rdata_hi;
   logic scan_active;
   logic next_scan_active;
   logic rdata_pending;
   logic next_rdata_pending;
   logic [1:0] delay;
   logic [1:0] next_delay;
   logic [7:0] next_sfr_rdata;
   logic busy;
   logic launch_read;
   logic launch_scan;
   logic launch_write;
   logic start;
   logic done;
   logic bit_strobe;
   logic sdo;
   logic sdi;
   logic [15:0] engine_rdata;
   logic [15:0] control_one;
   logic [15:0] control_two;
   logic link_now;

   assign busy = (state == PME_RUN);
   assign launch_read = sfr_write && sfr_addr == `PME_SFR_COMMAND
      && sfr_wdata[`PME_CMD_SINGLE_READ] && !mgmt_command_reg[`PME_CMD_SINGLE_READ];
   assign launch_scan = sfr_write && sfr_addr == `PME_SFR_COMMAND
      && sfr_wdata[`PME_CMD_CONT_READ] && !mgmt_command_reg[`PME_CMD_CONT_READ];
   assign launch_write = sfr_write && sfr_addr == `PME_SFR_WDATA_HI;

   // Host register writes
   always_comb begin
      next_reg_select = phy_reg_select;
      next_command = mgmt_command_reg;
      next_wdata_lo = mgmt_wdata_lo;
      next_wdata_hi = mgmt_wdata_hi;
      if (sfr_write) begin
         case (sfr_addr)
            `PME_SFR_REG_SELECT: next_reg_select = sfr_wdata[4:0];
            `PME_SFR_COMMAND: next_command = sfr_wdata[1:0];
            `PME_SFR_WDATA_LO: next_wdata_lo = sfr_wdata;
            `PME_SFR_WDATA_HI: next_wdata_hi = sfr_wdata;
            default: next_command = mgmt_command_reg;
         endcase
      end
   end

   // Transaction sequencer
   always_comb begin
      next_state = state;
      next_op = op;
      next_delay = delay;
      next_scan_active = scan_active;
      next_rdata_pending = rdata_pending;
      next_rdata_lo = mgmt_rdata_lo;
      next_rdata_hi = mgmt_rdata_hi;
      start = 1'b0;
      case (state)
         PME_IDLE: begin
            if (launch_scan) begin
               next_op = PME_OP_SCAN;
               next_state = PME_ARM;
               next_delay = 2'd1;
            end else if (launch_read) begin
               next_op = PME_OP_READ;
               next_state = PME_ARM;
               next_delay = 2'd1;
            end else if (launch_write) begin
               next_op = PME_OP_WRITE;
               next_state = PME_ARM;
               next_delay = 2'd1;
            end
         end
         PME_ARM: begin
            if (delay >= 2'(`PME_START_DELAY - 1)) begin
               next_state = PME_RUN;
               start = 1'b1;
               if (op == PME_OP_SCAN) begin
                  next_scan_active = 1'b1;
               end
               if (op != PME_OP_WRITE) begin
                  next_rdata_pending = 1'b1;
               end
            end else begin
               next_delay = delay + 2'd1;
            end
         end
         PME_RUN: begin
            if (done) begin
               if (op != PME_OP_WRITE) begin
                  next_rdata_lo = engine_rdata[7:0];
                  next_rdata_hi = engine_rdata[15:8];
                  next_rdata_pending = 1'b0;
               end
               if (op == PME_OP_SCAN && mgmt_command_reg[`PME_CMD_CONT_READ]) begin
                  start = 1'b1;
               end else begin
                  next_state = PME_IDLE;
                  next_scan_active = 1'b0;
               end
            end
         end
         default: next_state = PME_IDLE;
      endcase
   end

   // Host register reads
   always_comb begin
      next_sfr_rdata = 8'h00;
      if (sfr_read) begin
         case (sfr_addr)
            `PME_SFR_REG_SELECT: next_sfr_rdata = {3'h0, phy_reg_select};
            `PME_SFR_COMMAND: next_sfr_rdata = {6'h00, mgmt_command_reg};
            `PME_SFR_STATUS: begin
               next_sfr_rdata[`PME_STAT_BUSY] = busy;
               next_sfr_rdata[`PME_STAT_SCAN] = scan_active;
               next_sfr_rdata[`PME_STAT_PENDING] = rdata_pending;
            end
            `PME_SFR_WDATA_LO: next_sfr_rdata = mgmt_wdata_lo;
            `PME_SFR_WDATA_HI: next_sfr_rdata = mgmt_wdata_hi;
            `PME_SFR_RDATA_LO: next_sfr_rdata = mgmt_rdata_lo;
            `PME_SFR_RDATA_HI: next_sfr_rdata = mgmt_rdata_hi;
            default: next_sfr_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state <= PME_IDLE;
         op <= PME_OP_READ;
         delay <= 2'd0;
         phy_reg_select <= 5'h00;
         mgmt_command_reg <= 2'h0;
         mgmt_wdata_lo <= 8'h00;
         mgmt_wdata_hi <= 8'h00;
         mgmt_rdata_lo <= 8'h00;
         mgmt_rdata_hi <= 8'h00;
         scan_active <= 1'b0;
         rdata_pending <= 1'b0;
         sfr_rdata <= 8'h00;
      end else begin
         state <= next_state;
         op <= next_op;
         delay <= next_delay;
         phy_reg_select <= next_reg_select;
         mgmt_command_reg <= next_command;
         mgmt_wdata_lo <= next_wdata_lo;
         mgmt_wdata_hi <= next_wdata_hi;
         mgmt_rdata_lo <= next_rdata_lo;
         mgmt_rdata_hi <= next_rdata_hi;
         scan_active <= next_scan_active;
         rdata_pending <= next_rdata_pending;
         sfr_rdata <= next_sfr_rdata;
      end
   end

   pme_mgmt_serial #(
      .TXN_CYCLES(TXN_CYCLES)
   ) u_serial (
      .clock(clock),
      .rst(rst),
      .start(start),
      .wdata({mgmt_wdata_hi, mgmt_wdata_lo}),
      .sdi(sdi),
      .sdo(sdo),
      .bit_strobe(bit_strobe),
      .done(done),
      .rdata(engine_rdata)
   );

   pme_phy_regs u_phy (
      .clock(clock),
      .rst(rst),
      .start(start),
      .write_op(op == PME_OP_WRITE),
      .addr(phy_reg_select),
      .bit_strobe(bit_strobe),
      .sdo(sdo),
      .done(done),
      .link_pin(link_pin),
      .tx_pin(tx_pin),
      .rx_pin(rx_pin),
      .col_pin(col_pin),
      .sdi(sdi),
      .control_one(control_one),
      .control_two(control_two),
      .led_control(led_config),
      .link_now(link_now)
   );

   assign phy_duplex_select = control_one[`PME_DUPLEX_BIT];
   assign duplex_mismatch = phy_duplex_select != mac_duplex_select;
   assign force_link_up = control_two[`PME_FORCE_LINK_BIT];
   assign tx_allowed = force_link_up || link_now;
   assign loopback_off_ctrl = control_two[`PME_LOOPBACK_OFF_BIT];
   assign rx_pair_normal_ctrl = control_two[`PME_RX_PAIR_BIT];
endmodule : pme_access_engine

// ---- pme_access_engine_assertions.sv ----
// Purpose: Port checks of the engine
// Assumes: Host launches only while the engine is idle
// Notes: Bound to every engine instance
`timescale 1ns/100ps
`include "pme_defines.svh"
module pme_access_engine_assertions
   import pme_pkg::*;
#(
   parameter int TXN_CYCLES = `PME_TXN_CYCLES
) (
   input wire logic clock, // Clock
   input wire logic rst, // Reset
   input wire logic [2:0] sfr_addr, // Index
   input wire logic sfr_write, // Write
   input wire logic sfr_read, // Read
   input wire logic [7:0] sfr_wdata, // Write data
   input wire logic [7:0] sfr_rdata, // Read data
   input wire logic mac_duplex_select, // MAC duplex
   input wire logic phy_duplex_select, // PHY duplex
   input wire logic duplex_mismatch, // Differ
   input wire logic force_link_up, // Forced
   input wire logic tx_allowed, // Tx ok
   input wire logic loopback_off_ctrl, // Loopback off
   input wire logic rx_pair_normal_ctrl // Rx pair
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic launch;
   logic [3:0] ctl;
   logic [15:0] since;
   logic [15:0] next_since;
   assign launch = sfr_write && (sfr_addr == `PME_SFR_WDATA_HI ||
      (sfr_addr == `PME_SFR_COMMAND && sfr_wdata[1:0] != 2'h0));
   assign ctl = {phy_duplex_select, force_link_up, loopback_off_ctrl, rx_pair_normal_ctrl};
   // Cycles since accepted launch
   always_comb begin
      next_since = (since == 16'hffff) ? since : since + 16'h1;
      if (launch && since > 16'(TXN_CYCLES + 2)) next_since = 16'h0;
   end
   always_ff @(posedge clock) begin
      since <= rst ? 16'hffff : next_since;
   end
   sequence launch_s;
      launch;
   endsequence
   sequence stat_rd_s;
      sfr_read && sfr_addr == `PME_SFR_STATUS;
   endsequence
   a_busy_on_time: assert property (launch_s ##3 stat_rd_s |=> sfr_rdata[0])
      else $error("busy late after launch");
   a_pending_has_busy: assert property (stat_rd_s |=> !sfr_rdata[2] || sfr_rdata[0])
      else $error("pending without busy");
   a_scan_has_busy: assert property (stat_rd_s |=> !sfr_rdata[1] || sfr_rdata[0])
      else $error("scan without busy");
   a_cmd_two_bits: assert property (sfr_read && sfr_addr == `PME_SFR_COMMAND |=>
      sfr_rdata[7:2] == 6'h0) else $error("command upper bits set");
   a_select_five_bits: assert property (sfr_read && sfr_addr == `PME_SFR_REG_SELECT |=>
      sfr_rdata[7:5] == 3'h0) else $error("select upper bits set");
   a_ctl_after_frame: assert property ($changed(ctl) |-> since >= 16'(TXN_CYCLES))
      else $error("control changed early");
   a_duplex_flag: assert property (duplex_mismatch == (phy_duplex_select != mac_duplex_select))
      else $error("duplex mismatch wrong");
   a_force_tx: assert property (force_link_up |-> tx_allowed)
      else $error("forced link blocks tx");
endmodule : pme_access_engine_assertions
bind pme_access_engine pme_access_engine_assertions #(.TXN_CYCLES(TXN_CYCLES))
   pme_access_engine_assertions_inst (.clock, .rst, .sfr_addr, .sfr_write, .sfr_read,
   .sfr_wdata, .sfr_rdata, .mac_duplex_select, .phy_duplex_select, .duplex_mismatch,
   .force_link_up, .tx_allowed, .loopback_off_ctrl, .rx_pair_normal_ctrl);

// ---- pme_defines.svh ----
// Purpose: Engine constants
// Assumes: 200 MHz clock; one transaction lasts 10.24 us
// Notes: Offsets, fields, resets, timing
`ifndef PME_DEFINES_SVH
`define PME_DEFINES_SVH

// Timing
`define PME_CLK_MHZ 200
`define PME_TXN_NS 10240
`define PME_TXN_CYCLES ((`PME_TXN_NS * `PME_CLK_MHZ) / 1000)
`define PME_FRAME_SLOTS 32
`define PME_DATA_SLOTS 16
`define PME_START_DELAY 2

// Host register indices
`define PME_SFR_REG_SELECT 3'h0
`define PME_SFR_COMMAND 3'h1
`define PME_SFR_STATUS 3'h2
`define PME_SFR_WDATA_LO 3'h3
`define PME_SFR_WDATA_HI 3'h4
`define PME_SFR_RDATA_LO 3'h5
`define PME_SFR_RDATA_HI 3'h6

// Command and status fields
`define PME_CMD_SINGLE_READ 0
`define PME_CMD_CONT_READ 1
`define PME_STAT_BUSY 0
`define PME_STAT_SCAN 1
`define PME_STAT_PENDING 2

// PHY register addresses
`define PME_PHY_CONTROL_ONE 5'h00
`define PME_PHY_STATUS_ONE 5'h01
`define PME_PHY_CONTROL_TWO 5'h10
`define PME_PHY_STATUS_TWO 5'h11
`define PME_PHY_IRQ_ENABLE 5'h12
`define PME_PHY_IRQ_FLAGS 5'h13
`define PME_PHY_LED_CONTROL 5'h14

// PHY register fields
`define PME_DUPLEX_BIT 8
`define PME_LATCHED_LINK_BIT 2
`define PME_FORCE_LINK_BIT 14
`define PME_LOOPBACK_OFF_BIT 8
`define PME_RX_PAIR_BIT 4
`define PME_STAT2_TX_BIT 13
`define PME_STAT2_RX_BIT 12
`define PME_STAT2_COL_BIT 11
`define PME_STAT2_LINK_BIT 10
`define PME_IRQ_LINK_BIT 4
`define PME_IRQ_GLOBAL_BIT 2
`define PME_IRQ_EN_LINK_BIT 4
`define PME_IRQ_EN_GLOBAL_BIT 1

// PHY reset values and masks
`define PME_CONTROL_ONE_RESET 16'h0000
`define PME_CONTROL_ONE_MASK 16'hcd80
`define PME_STATUS_ONE_FIXED 16'h1800
`define PME_CONTROL_TWO_RESET 16'h0000
`define PME_CONTROL_TWO_MASK 16'h7fff
`define PME_IRQ_ENABLE_RESET 16'h0000
`define PME_IRQ_ENABLE_MASK 16'h0012
`define PME_LED_CONTROL_RESET 16'h3422

`endif

// ---- pme_mgmt_serial.sv ----
// Purpose: Serial link master, one frame per transaction
// Assumes: start is a one-cycle pulse; wdata stable at start
// Notes: Data moves MSB first in the last 16 of 32 bit slots
`timescale 1ns/100ps
`include "pme_defines.svh"
module pme_mgmt_serial
   import pme_pkg::*;
#(
   parameter int TXN_CYCLES = `PME_TXN_CYCLES
) (
   input wire logic clock,        // System clock
   input wire logic rst,          // Synchronous reset
   input wire logic start,        // Begin a frame
   input wire logic [15:0] wdata, // Word to send
   input wire logic sdi,          // Serial data from PHY
   output logic sdo,              // Serial data to PHY
   output logic bit_strobe,       // Data bit edge
   output logic done,             // Frame finished, rdata valid
   output logic [15:0] rdata      // Word received
);
   localparam int BIT_CYCLES = TXN_CYCLES / `PME_FRAME_SLOTS;
   localparam int CW = $clog2(TXN_CYCLES + 1);

   logic active;
   logic [CW-1:0] count;
   logic [15:0] shift;
   logic next_active;
   logic [CW-1:0] next_count;
   logic [15:0] next_shift;
   logic next_done;
   logic last;

   assign last = active && (count == CW'(TXN_CYCLES - 1));
   assign bit_strobe = active && (int'(count) / BIT_CYCLES >= `PME_DATA_SLOTS)
                       && (int'(count) % BIT_CYCLES == BIT_CYCLES - 1);
   assign sdo = shift[15];
   assign rdata = shift;

   always_comb begin
      next_active = active;
      next_count = count;
      next_shift = shift;
      next_done = last;
      if (start) begin
         next_active = 1'b1;
         next_count = '0;
         next_shift = wdata;
      end else if (active) begin
         next_count = count + 1'b1;
         if (bit_strobe) begin
            next_shift = {shift[14:0], sdi};
         end
         if (last) begin
            next_active = 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         active <= 1'b0;
         count <= '0;
         shift <= 16'h0000;
         done <= 1'b0;
      end else begin
         active <= next_active;
         count <= next_count;
         shift <= next_shift;
         done <= next_done;
      end
   end
endmodule : pme_mgmt_serial

// ---- pme_phy_line_model.sv ----
// Purpose: PHY analog line levels seen by the engine
// Assumes: Bench sets the link level
// Notes: Activity lines keep toggling
`timescale 1ns/100ps
module pme_phy_line_model (
   input wire logic clock,  // Clock
   input wire logic link_up, // Wanted link
   output logic link_pin,   // Link level
   output logic tx_pin,     // Tx activity
   output logic rx_pin,     // Rx activity
   output logic col_pin     // Collision
);
   logic [2:0] act = 3'h0;
   always @(posedge clock) act <= act + 3'h1;
   assign link_pin = link_up;
   assign tx_pin = act[1];
   assign rx_pin = act[2];
   assign col_pin = act[1] & act[2];
endmodule : pme_phy_line_model

// ---- pme_phy_regs.sv ----
// Purpose: PHY register set behind the serial link
// Assumes: Status pins come from PHY analog logic in another domain
// Notes: Clear-on-read takes effect at frame end
`timescale 1ns/100ps
`include "pme_defines.svh"
module pme_phy_regs
   import pme_pkg::*;
(
   input wire logic clock,          // System clock
   input wire logic rst,            // Synchronous reset
   input wire logic start,          // Frame begins
   input wire logic write_op,       // Frame is a write
   input wire logic [4:0] addr,     // Target PHY register
   input wire logic bit_strobe,     // Data bit edge
   input wire logic sdo,            // From engine
   input wire logic done,           // Frame finished
   input wire logic link_pin,       // Raw link up level
   input wire logic tx_pin,         // Raw transmit activity
   input wire logic rx_pin,         // Raw receive activity
   input wire logic col_pin,        // Raw collision
   output logic sdi,                // To engine
   output logic [15:0] control_one, // Control one
   output logic [15:0] control_two, // Control two
   output logic [15:0] led_control, // LED control
   output logic link_now            // Synced link
);
   logic [3:0] meta;
   logic [3:0] pins;
   logic latched_link_up;
   logic [15:0] irq_enable;
   logic link_flag;
   logic link_prev;
   logic [15:0] out_shift;
   logic [15:0] in_shift;
   logic [15:0] read_value;
   logic [15:0] next_control_one;
   logic [15:0] next_control_two;
   logic [15:0] next_led_control;
   logic [15:0] next_irq_enable;
   logic next_latched;
   logic next_link_flag;
   logic [15:0] next_out_shift;
   logic [15:0] next_in_shift;
   logic commit;
   logic read_done;

   assign link_now = pins[0];
   assign sdi = out_shift[15];
   assign commit = done && write_op;
   assign read_done = done && !write_op;

   always_comb begin
      read_value = 16'h0000;
      case (addr)
         `PME_PHY_CONTROL_ONE: read_value = control_one;
         `PME_PHY_STATUS_ONE: begin
            read_value = `PME_STATUS_ONE_FIXED;
            read_value[`PME_LATCHED_LINK_BIT] = latched_link_up;
         end
         `PME_PHY_CONTROL_TWO: read_value = control_two;
         `PME_PHY_STATUS_TWO: begin
            read_value[`PME_STAT2_TX_BIT] = pins[1];
            read_value[`PME_STAT2_RX_BIT] = pins[2];
            read_value[`PME_STAT2_COL_BIT] = pins[3];
            read_value[`PME_STAT2_LINK_BIT] = pins[0];
         end
         `PME_PHY_IRQ_ENABLE: read_value = irq_enable;
         `PME_PHY_IRQ_FLAGS: begin
            read_value[`PME_IRQ_LINK_BIT] = link_flag;
            read_value[`PME_IRQ_GLOBAL_BIT] = link_flag
               && irq_enable[`PME_IRQ_EN_LINK_BIT] && irq_enable[`PME_IRQ_EN_GLOBAL_BIT];
         end
         `PME_PHY_LED_CONTROL: read_value = led_control;
         default: read_value = 16'h0000;
      endcase
   end

   always_comb begin
      next_control_one = control_one;
      next_control_two = control_two;
      next_led_control = led_control;
      next_irq_enable = irq_enable;
      next_out_shift = out_shift;
      next_in_shift = in_shift;
      next_latched = latched_link_up && pins[0];
      next_link_flag = link_flag;
      if (read_done && addr == `PME_PHY_STATUS_ONE) begin
         next_latched = pins[0];
      end
      if (read_done && addr == `PME_PHY_IRQ_FLAGS) begin
         next_link_flag = 1'b0;
      end
      if (pins[0] != link_prev) begin
         next_link_flag = 1'b1;
      end
      if (start) begin
         next_out_shift = read_value;
      end else if (bit_strobe) begin
         next_out_shift = {out_shift[14:0], 1'b0};
         next_in_shift = {in_shift[14:0], sdo};
      end
      if (commit) begin
         case (addr)
            `PME_PHY_CONTROL_ONE: next_control_one = in_shift & `PME_CONTROL_ONE_MASK;
            `PME_PHY_CONTROL_TWO: next_control_two = in_shift & `PME_CONTROL_TWO_MASK;
            `PME_PHY_IRQ_ENABLE: next_irq_enable = in_shift & `PME_IRQ_ENABLE_MASK;
            `PME_PHY_LED_CONTROL: next_led_control = in_shift;
            default: next_led_control = led_control;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         meta <= 4'h0;
         pins <= 4'h0;
         link_prev <= 1'b0;
         latched_link_up <= 1'b0;
         link_flag <= 1'b0;
         control_one <= `PME_CONTROL_ONE_RESET;
         control_two <= `PME_CONTROL_TWO_RESET;
         led_control <= `PME_LED_CONTROL_RESET;
         irq_enable <= `PME_IRQ_ENABLE_RESET;
         out_shift <= 16'h0000;
         in_shift <= 16'h0000;
      end else begin
         meta <= {col_pin, rx_pin, tx_pin, link_pin};
         pins <= meta;
         link_prev <= pins[0];
         latched_link_up <= next_latched;
         link_flag <= next_link_flag;
         control_one <= next_control_one;
         control_two <= next_control_two;
         led_control <= next_led_control;
         irq_enable <= next_irq_enable;
         out_shift <= next_out_shift;
         in_shift <= next_in_shift;
      end
   end
endmodule : pme_phy_regs

// ---- pme_pkg.sv ----
// Purpose: Engine types
// Assumes: Nothing beyond the defines header
// Notes: States and operation kinds
package pme_pkg;

   typedef enum logic [1:0] {
      PME_IDLE = 2'b00,
      PME_ARM = 2'b01,
      PME_RUN = 2'b10
   } pme_state_type;

   typedef enum logic [1:0] {
      PME_OP_READ = 2'b00,
      PME_OP_WRITE = 2'b01,
      PME_OP_SCAN = 2'b10
   } pme_op_type;

endpackage : pme_pkg

// ---- tb_top.sv ----
// Purpose: Self-checking bench of the engine
// Assumes: Short frames via TXN_CYCLES
// Notes: PHY registers reached through the engine
`timescale 1ns/100ps
`include "pme_defines.svh"
module tb_top;
   import pme_pkg::*;
   localparam int T = 64;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [2:0] sfr_addr = 3'h0;
   logic sfr_write = 1'b0;
   logic sfr_read = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic mac_duplex_select = 1'b0;
   logic link_up = 1'b1;
   logic [7:0] sfr_rdata, s;
   logic link_pin, tx_pin, rx_pin, col_pin, phy_duplex_select, duplex_mismatch;
   logic force_link_up, tx_allowed, loopback_off_ctrl, rx_pair_normal_ctrl;
   logic [15:0] led_config, v;
   int failures = 0;
   int num_checks = 0;
   int cyc;
   initial forever #2.5 clock = ~clock;
   pme_phy_line_model pme_phy_line_model_inst (.clock, .link_up, .link_pin, .tx_pin,
      .rx_pin, .col_pin);
   pme_access_engine #(.TXN_CYCLES(T)) pme_access_engine_inst (.clock, .rst, .sfr_addr,
      .sfr_write, .sfr_read, .sfr_wdata, .sfr_rdata, .mac_duplex_select, .link_pin,
      .tx_pin, .rx_pin, .col_pin, .phy_duplex_select, .duplex_mismatch, .force_link_up,
      .tx_allowed, .loopback_off_ctrl, .rx_pair_normal_ctrl, .led_config);
   task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_write <= 1'b1;
      @(posedge clock);
      sfr_write <= 1'b0;
   endtask : wr
   task rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clock);
      sfr_addr <= a;
      sfr_read <= 1'b1;
      @(posedge clock);
      sfr_read <= 1'b0;
      #1 d = sfr_rdata;
   endtask : rd
   // Poll busy; cyc counts edges from entry
   task idle;
      cyc = 2;
      repeat (2) @(posedge clock);
      do begin
         rd(`PME_SFR_STATUS, s);
         cyc += 2;
      end while (s[0] !== 1'b0 && cyc < 4 * T);
      chk(16'(cyc < 4 * T), 16'h1, "busy stuck");
   endtask : idle
   task phy_wr(input logic [4:0] a, input logic [15:0] d);
      wr(`PME_SFR_REG_SELECT, {3'h0, a});
      wr(`PME_SFR_WDATA_LO, d[7:0]);
      wr(`PME_SFR_WDATA_HI, d[15:8]);
      idle;
   endtask : phy_wr
   task phy_rd(input logic [4:0] a);
      wr(`PME_SFR_REG_SELECT, {3'h0, a});
      wr(`PME_SFR_COMMAND, 8'h01);
      idle;
      wr(`PME_SFR_COMMAND, 8'h00);
      rd(`PME_SFR_RDATA_LO, v[7:0]);
      rd(`PME_SFR_RDATA_HI, v[15:8]);
   endtask : phy_rd
   task t_reset;
      rd(`PME_SFR_STATUS, s);
      chk(16'(s), 16'h0, "reset status");
      rd(3'h7, s);
      chk(16'(s), 16'h0, "unmapped index");
      chk(led_config, 16'h3422, "led reset");
      phy_rd(`PME_PHY_CONTROL_TWO);
      chk(v, 16'h0000, "control two reset");
      phy_rd(`PME_PHY_STATUS_ONE);
      chk(v & 16'hfff9, 16'h1800, "status one fixed");
      phy_rd(`PME_PHY_STATUS_ONE);
      chk(v & 16'hfffd, 16'h1804, "status one link up");
      $display("test reset done");
   endtask : t_reset
   task t_write;
      phy_wr(`PME_PHY_CONTROL_ONE, 16'h0100);
      chk(16'({phy_duplex_select, duplex_mismatch}), 16'h3, "duplex set");
      @(posedge clock);
      mac_duplex_select <= 1'b1;
      @(posedge clock);
      #1 chk(16'(duplex_mismatch), 16'h0, "duplex agree");
      phy_rd(`PME_PHY_CONTROL_ONE);
      chk(v, 16'h0100, "control one");
      phy_wr(`PME_PHY_CONTROL_TWO, 16'h4110);
      chk(16'({force_link_up, loopback_off_ctrl, rx_pair_normal_ctrl}), 16'h7, "ctl two");
      phy_wr(`PME_PHY_CONTROL_TWO, 16'h0010);
      phy_rd(`PME_PHY_CONTROL_TWO);
      chk(v, 16'h0010, "whole word");
      $display("test write done");
   endtask : t_write
   task t_timing;
      wr(`PME_SFR_REG_SELECT, {3'h0, `PME_PHY_CONTROL_ONE});
      wr(`PME_SFR_COMMAND, 8'h01);
      @(posedge clock);
      rd(`PME_SFR_STATUS, s);
      chk(16'(s), 16'h05, "busy pending");
      idle;
      chk(16'(cyc + 3 >= T + 2 && cyc + 3 <= T + 6), 16'h1, "read length");
      rd(`PME_SFR_COMMAND, s);
      chk(16'(s), 16'h01, "command kept");
      wr(`PME_SFR_COMMAND, 8'h00);
      rd(`PME_SFR_REG_SELECT, s);
      chk(16'(s), 16'h00, "select kept");
      rd(`PME_SFR_RDATA_LO, v[7:0]);
      rd(`PME_SFR_RDATA_HI, v[15:8]);
      chk(v, 16'h0100, "read result");
      wr(`PME_SFR_REG_SELECT, {3'h0, `PME_PHY_CONTROL_TWO});
      wr(`PME_SFR_WDATA_HI, 8'h01);
      wr(`PME_SFR_WDATA_HI, 8'h41);
      idle;
      phy_rd(`PME_PHY_CONTROL_TWO);
      chk(v, 16'h0110, "launch ignored");
      $display("test timing done");
   endtask : t_timing
   task t_scan;
      wr(`PME_SFR_REG_SELECT, {3'h0, `PME_PHY_STATUS_TWO});
      wr(`PME_SFR_COMMAND, 8'h02);
      @(posedge clock);
      rd(`PME_SFR_STATUS, s);
      chk(16'(s), 16'h07, "scan flags");
      repeat (T + 8) @(posedge clock);
      rd(`PME_SFR_STATUS, s);
      chk(16'(s), 16'h03, "scan first");
      rd(`PME_SFR_RDATA_HI, s);
      chk(16'(s[2]), 16'h1, "scan link up");
      link_up <= 1'b0;
      repeat (2 * T + 8) @(posedge clock);
      rd(`PME_SFR_RDATA_HI, s);
      chk(16'(s[2]), 16'h0, "scan refreshed");
      chk(16'(tx_allowed), 16'h0, "transmit blocked");
      wr(`PME_SFR_COMMAND, 8'h00);
      idle;
      chk(16'(cyc <= T + 6), 16'h1, "scan end");
      rd(`PME_SFR_STATUS, s);
      chk(16'(s), 16'h00, "scan clear");
      link_up <= 1'b1;
      phy_rd(`PME_PHY_STATUS_ONE);
      chk(16'(v[2]), 16'h0, "loss latched");
      phy_rd(`PME_PHY_STATUS_ONE);
      chk(16'(v[2]), 16'h1, "latch reloaded");
      $display("test scan done");
   endtask : t_scan
   task report_and_stop;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      $display("unexpected at %0t: watchdog expired", $time);
      report_and_stop;
   end
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      t_reset;
      t_write;
      t_timing;
      t_scan;
      report_and_stop;
   end
endmodule : tb_top
